//--- inc/wso_defines.vh
// Notes on behaviour
// - Setting the WAN select control bit enters WAN operation; clearing returns to LAN.
// - A read-only status bit reports whether WAN operation is currently active.
// - Transmit and receive paths always share the single WAN setting.
// - Transmit takes PCS bytes and places them in the payload envelope.
// - Transmit builds overhead octets, scrambles the frame apart from the first-row framing, trace and growth octets and sends it to the PMA.
// - Receive finds frame boundaries in PMA data and descrambles before overhead work.
// - Receive examines overhead and detects framing loss and section parity errors.
// - Receive takes payload at the fixed pointer position and passes it to the PCS.
// - Transmitted framing octets come from a register, default F6 and 28, port reachable.
// - Section trace repeats a 1, 16 or 64 byte message; separate tx and rx stores.
// - Growth and orderwire octets come from one register, default CC and 00, port reachable.
// - User channel and three data channel octets come from registers, default 00.
// - Transmit port mask bit of one inverts that section parity bit; zero leaves it.
// - Receive port shows the bit positions of detected section parity errors.
// - Parity errors accumulate in a counter latched periodically into two readable words.
// - Register overhead values are sent unchanged every frame; per-frame changes use the port.
// - Every first-framing octet carries the first value, every second one the second value.
`ifndef WSO_DEFINES_VH
`define WSO_DEFINES_VH

// Register addresses
`define WSO_ADDR_CTRL      16'h0007
`define WSO_ADDR_STAT      16'hA101
`define WSO_ADDR_A1A2      16'hE600
`define WSO_ADDR_Z0E1      16'hE601
`define WSO_ADDR_F1D1      16'hE602
`define WSO_ADDR_D2D3      16'hE603
`define WSO_ADDR_TXLEN     16'hE604
`define WSO_ADDR_RXLEN     16'hE605
`define WSO_ADDR_TALLY_HI  16'hE606
`define WSO_ADDR_TALLY_LO  16'hE607
`define WSO_ADDR_IRQ_STAT  16'hE608
`define WSO_ADDR_IRQ_MASK  16'hE609
`define WSO_ADDR_TXMSG     16'hE640
`define WSO_ADDR_RXMSG     16'hE680
`define WSO_MSG_WORDS      6'h20

// Field positions
`define WSO_CTRL_WAN_BIT   0
`define WSO_STAT_WAN_BIT   3
`define WSO_STAT_SYNC_BIT  0

// Reset values
`define WSO_RST_A1A2       16'hF628
`define WSO_RST_Z0E1       16'hCC00
`define WSO_RST_F1D1       16'h0000
`define WSO_RST_D2D3       16'h0000
`define WSO_RST_LEN        2'h0

// Trace length codes
`define WSO_LEN_1          2'h0
`define WSO_LEN_16         2'h1

// Scrambler seed and framing
`define WSO_SCR_SEED       7'h7F
`define WSO_SYNC_EXIT      3'h4

// Overhead octet codes on the serial ports
`define WSO_OH_NONE        4'h0
`define WSO_OH_A1          4'h1
`define WSO_OH_A2          4'h2
`define WSO_OH_J0          4'h3
`define WSO_OH_Z0          4'h4
`define WSO_OH_B1          4'h5
`define WSO_OH_E1          4'h6
`define WSO_OH_F1          4'h7
`define WSO_OH_D1          4'h8
`define WSO_OH_D2          4'h9
`define WSO_OH_D3          4'hA

// Interrupt bits
`define WSO_IRQ_B1ERR      0
`define WSO_IRQ_SYNC       1
`define WSO_IRQ_LATCH      2

`endif

//--- hw/wso_framer.v
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`include "wso_defines.vh"

module wso_framer #(
  parameter N            = 192,
  parameter LATCH_FRAMES = 8000
) (
  input  wire        clock_i,
  input  wire        rst_n_i,
  input  wire [15:0] addr_i,
  input  wire [15:0] wr_data_i,
  input  wire        wr_stb_i,
  input  wire        rd_stb_i,
  output reg  [15:0] rd_data_o,
  output reg         irq_o,
  input  wire [7:0]  pcs_tx_data_i,
  input  wire        pcs_tx_valid_i,
  output reg         pcs_tx_ready_o,
  output reg  [7:0]  pma_tx_data_o,
  output reg         pma_tx_valid_o,
  input  wire [7:0]  pma_rx_data_i,
  input  wire        pma_rx_valid_i,
  output reg  [7:0]  pcs_rx_data_o,
  output reg         pcs_rx_valid_o,
  output reg  [3:0]  tx_osp_code_o,
  input  wire        tx_osp_en_i,
  input  wire [7:0]  tx_osp_byte_i,
  output reg  [3:0]  rx_osp_code_o,
  output reg  [7:0]  rx_osp_byte_o,
  output reg         rx_osp_valid_o
);

  // ==========================================================
  // Frame geometry
  localparam [14:0] C_N    = N;
  localparam [14:0] C_N2   = 2 * N;
  localparam [14:0] C_N3   = 3 * N;
  localparam [14:0] C_LAST = 90 * N - 1;
  localparam [3:0]  R_LAST = 4'h8;
  localparam [15:0] L_LAST = LATCH_FRAMES - 1;
  localparam        ST_HUNT = 1'b0;
  localparam        ST_SYNC = 1'b1;

  // Overhead octet code of a frame position
  function [3:0] oh_code;
    input [3:0]  row;
    input [14:0] col;
    begin
      oh_code = `WSO_OH_NONE;
      if (row == 4'h0) begin
        if (col < C_N)        oh_code = `WSO_OH_A1;
        else if (col < C_N2)  oh_code = `WSO_OH_A2;
        else if (col == C_N2) oh_code = `WSO_OH_J0;
        else if (col < C_N3)  oh_code = `WSO_OH_Z0;
      end else if (row == 4'h1) begin
        if (col == 15'h0000)  oh_code = `WSO_OH_B1;
        else if (col == C_N)  oh_code = `WSO_OH_E1;
        else if (col == C_N2) oh_code = `WSO_OH_F1;
      end else if (row == 4'h2) begin
        if (col == 15'h0000)  oh_code = `WSO_OH_D1;
        else if (col == C_N)  oh_code = `WSO_OH_D2;
        else if (col == C_N2) oh_code = `WSO_OH_D3;
      end
    end
  endfunction

  // One byte of x^7+x^6+1 keystream, returns {next state, mask}
  function [14:0] scr_step;
    input [6:0] st;
    reg   [6:0] s;
    reg   [7:0] m;
    integer     k;
    begin
      s = st;
      m = 8'h00;
      for (k = 7; k >= 0; k = k - 1) begin
        m[k] = s[6];
        s    = {s[5:0], s[6] ^ s[5]};
      end
      scr_step = {s, m};
    end
  endfunction

  // Trace message length in bytes minus one
  function [5:0] len_last;
    input [1:0] code;
    begin
      case (code)
        `WSO_LEN_1:  len_last = 6'h00;
        `WSO_LEN_16: len_last = 6'h0F;
        default:     len_last = 6'h3F;
      endcase
    end
  endfunction

  // ==========================================================
  // Registers
  reg        wan_sel;
  reg        wan_active;
  reg [15:0] a1a2, z0e1, f1d1, d2d3;
  reg [1:0]  tx_len, rx_len;
  reg [15:0] tally_hi, tally_lo;
  reg [2:0]  irq_stat, irq_mask;
  reg [7:0]  tx_msg [0:63];
  reg [7:0]  rx_msg [0:63];

  // Transmit state
  reg [3:0]  trow;
  reg [14:0] tcol;
  reg [6:0]  tscr;
  reg [7:0]  tbip, tb1;
  reg [5:0]  tj0;
  reg [15:0] lat_cnt;

  // Receive state
  reg        rstate;
  reg [2:0]  miss;
  reg [7:0]  rprev;
  reg [3:0]  rrow;
  reg [14:0] rcol;
  reg [6:0]  rscr;
  reg [7:0]  rbip, rb1;
  reg        rb1_ok;
  reg [5:0]  rj0;
  reg [31:0] tally;

  // ==========================================================
  // Transmit frame assembly
  reg  [3:0]  tcode;
  reg  [7:0]  tbyte, tout;
  reg  [14:0] next_tscr_m;
  reg  [6:0]  next_tscr;
  reg  [3:0]  next_trow;
  reg  [14:0] next_tcol;
  wire        tfr_end = (trow == R_LAST) && (tcol == C_LAST);
  wire        trow0   = (trow == 4'h0) && (tcol < C_N3);
  wire        tpay    = tcol > C_N3;

  always @* begin
    tcode = oh_code(trow, tcol);
    case (tcode)
      `WSO_OH_A1: tbyte = a1a2[15:8];
      `WSO_OH_A2: tbyte = a1a2[7:0];
      `WSO_OH_J0: tbyte = tx_msg[tj0];
      `WSO_OH_Z0: tbyte = z0e1[15:8];
      `WSO_OH_E1: tbyte = z0e1[7:0];
      `WSO_OH_F1: tbyte = f1d1[15:8];
      `WSO_OH_D1: tbyte = f1d1[7:0];
      `WSO_OH_D2: tbyte = d2d3[15:8];
      `WSO_OH_D3: tbyte = d2d3[7:0];
      `WSO_OH_B1: tbyte = tb1 ^ (tx_osp_en_i ? tx_osp_byte_i : 8'h00);
      default:    tbyte = (tpay && pcs_tx_valid_i) ? pcs_tx_data_i : 8'h00;
    endcase
    // Port override of a static octet, B1 only takes a mask
    if (tx_osp_en_i && tcode != `WSO_OH_NONE && tcode != `WSO_OH_B1)
      tbyte = tx_osp_byte_i;
    next_tscr_m = scr_step(tscr);
    tout        = trow0 ? tbyte : (tbyte ^ next_tscr_m[7:0]);
    next_tscr   = trow0 ? `WSO_SCR_SEED : next_tscr_m[14:8];
    next_trow   = trow;
    next_tcol   = tcol + 15'h0001;
    if (tcol == C_LAST) begin
      next_tcol = 15'h0000;
      next_trow = (trow == R_LAST) ? 4'h0 : trow + 4'h1;
    end
  end

  // Transmit pipeline and section parity
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      trow           <= 4'h0;
      tcol           <= 15'h0000;
      tscr           <= `WSO_SCR_SEED;
      tbip           <= 8'h00;
      tb1            <= 8'h00;
      tj0            <= 6'h00;
      pma_tx_data_o  <= 8'h00;
      pma_tx_valid_o <= 1'b0;
      pcs_tx_ready_o <= 1'b1;
      tx_osp_code_o  <= `WSO_OH_NONE;
    end else if (!wan_active) begin
      // LAN operation passes the PCS stream straight through
      trow           <= 4'h0;
      tcol           <= 15'h0000;
      tscr           <= `WSO_SCR_SEED;
      tbip           <= 8'h00;
      pma_tx_data_o  <= pcs_tx_data_i;
      pma_tx_valid_o <= pcs_tx_valid_i;
      pcs_tx_ready_o <= !wan_sel;
      tx_osp_code_o  <= wan_sel ? `WSO_OH_A1 : `WSO_OH_NONE;
    end else begin
      trow           <= next_trow;
      tcol           <= next_tcol;
      tscr           <= next_tscr;
      pma_tx_data_o  <= tout;
      pma_tx_valid_o <= 1'b1;
      // A pending return to LAN makes the next cycle a pass-through one
      pcs_tx_ready_o <= !wan_sel || next_tcol > C_N3;
      tx_osp_code_o  <= wan_sel ? oh_code(next_trow, next_tcol) : `WSO_OH_NONE;
      if (tfr_end) begin
        tb1  <= tbip ^ tout;
        tbip <= 8'h00;
        tj0  <= (tj0 >= len_last(tx_len)) ? 6'h00 : tj0 + 6'h01;
      end else begin
        tbip <= tbip ^ tout;
      end
    end
  end

  // ==========================================================
  // Receive framing, descrambling and overhead
  reg  [3:0]  rcode;
  reg  [14:0] next_rscr_m;
  reg  [7:0]  rdesc, rerr;
  reg  [3:0]  rpop;
  reg  [3:0]  next_rrow;
  reg  [14:0] next_rcol;
  integer     b;
  wire        rfr_end = (rrow == R_LAST) && (rcol == C_LAST);
  wire        rrow0   = (rrow == 4'h0) && (rcol < C_N3);
  wire        rlive   = wan_active && pma_rx_valid_i && rstate == ST_SYNC;
  wire        rhit    = (rprev == a1a2[15:8]) && (pma_rx_data_i == a1a2[7:0]);

  always @* begin
    rcode       = oh_code(rrow, rcol);
    next_rscr_m = scr_step(rscr);
    rdesc       = rrow0 ? pma_rx_data_i : (pma_rx_data_i ^ next_rscr_m[7:0]);
    rerr        = (rcode == `WSO_OH_B1 && rb1_ok) ? (rdesc ^ rb1) : 8'h00;
    rpop        = 4'h0;
    for (b = 0; b < 8; b = b + 1)
      rpop = rpop + {3'h0, rerr[b]};
    next_rrow = rrow;
    next_rcol = rcol + 15'h0001;
    if (rcol == C_LAST) begin
      next_rcol = 15'h0000;
      next_rrow = (rrow == R_LAST) ? 4'h0 : rrow + 4'h1;
    end
  end

  wire        sync_lost = rlive && rrow == 4'h0 && rcol == C_N && !rhit
                          && miss == (`WSO_SYNC_EXIT - 3'h1);
  wire        sync_got  = wan_active && pma_rx_valid_i && rstate == ST_HUNT && rhit;
  wire [15:0] next_lat  = (wan_active && tfr_end) ?
                          ((lat_cnt == L_LAST) ? 16'h0000 : lat_cnt + 16'h0001) : lat_cnt;
  wire        latch_now = wan_active && tfr_end && lat_cnt == L_LAST;
  wire [31:0] next_tally = tally + {28'h0000000, rpop};

  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      rstate         <= ST_HUNT;
      miss           <= 3'h0;
      rprev          <= 8'h00;
      rrow           <= 4'h0;
      rcol           <= 15'h0000;
      rscr           <= `WSO_SCR_SEED;
      rbip           <= 8'h00;
      rb1            <= 8'h00;
      rb1_ok         <= 1'b0;
      rj0            <= 6'h00;
      pcs_rx_data_o  <= 8'h00;
      pcs_rx_valid_o <= 1'b0;
      rx_osp_code_o  <= `WSO_OH_NONE;
      rx_osp_byte_o  <= 8'h00;
      rx_osp_valid_o <= 1'b0;
    end else if (!wan_active) begin
      rstate         <= ST_HUNT;
      rb1_ok         <= 1'b0;
      pcs_rx_data_o  <= pma_rx_data_i;
      pcs_rx_valid_o <= pma_rx_valid_i;
      rx_osp_valid_o <= 1'b0;
    end else begin
      pcs_rx_valid_o <= 1'b0;
      rx_osp_valid_o <= 1'b0;
      if (pma_rx_valid_i)
        rprev <= pma_rx_data_i;
      if (sync_got) begin
        // First second-framing octet found, next byte follows it
        rstate <= ST_SYNC;
        miss   <= 3'h0;
        rrow   <= 4'h0;
        rcol   <= C_N + 15'h0001;
        rscr   <= `WSO_SCR_SEED;
        rbip   <= pma_rx_data_i;
        rb1_ok <= 1'b0;
      end else if (rlive) begin
        rrow <= next_rrow;
        rcol <= next_rcol;
        rscr <= rrow0 ? `WSO_SCR_SEED : next_rscr_m[14:8];
        if (rrow == 4'h0 && rcol == C_N) begin
          if (sync_lost)
            rstate <= ST_HUNT;
          miss <= rhit ? 3'h0 : miss + 3'h1;
        end
        if (rfr_end) begin
          rb1    <= rbip ^ pma_rx_data_i;
          rbip   <= 8'h00;
          rb1_ok <= 1'b1;
          rj0    <= (rj0 >= len_last(rx_len)) ? 6'h00 : rj0 + 6'h01;
        end else begin
          rbip <= rbip ^ pma_rx_data_i;
        end
        pcs_rx_data_o  <= rdesc;
        pcs_rx_valid_o <= rcol > C_N3;
        rx_osp_code_o  <= rcode;
        rx_osp_byte_o  <= (rcode == `WSO_OH_B1) ? rerr : rdesc;
        rx_osp_valid_o <= rcode != `WSO_OH_NONE;
      end
    end
  end

  // Received trace bytes land in the receive message store
  always @(posedge clock_i) begin
    if (rlive && rcode == `WSO_OH_J0)
      rx_msg[rj0] <= rdesc;
  end

  // ==========================================================
  // Parity error tally and periodic latch
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      tally    <= 32'h00000000;
      lat_cnt  <= 16'h0000;
      tally_hi <= 16'h0000;
      tally_lo <= 16'h0000;
    end else begin
      lat_cnt <= next_lat;
      if (latch_now) begin
        tally_hi <= next_tally[31:16];
        tally_lo <= next_tally[15:0];
        tally    <= 32'h00000000;
      end else if (rlive) begin
        tally <= next_tally;
      end
    end
  end

  // ==========================================================
  // Register writes, interrupt status and mode
  wire [2:0] irq_evt = {latch_now, sync_got | sync_lost, rlive && rerr != 8'h00};
  wire       wr_ctl  = wr_stb_i;
  wire [2:0] irq_clr = (wr_ctl && addr_i == `WSO_ADDR_IRQ_STAT) ? wr_data_i[2:0] : 3'h0;
  wire [2:0] next_irq_stat = (irq_stat & ~irq_clr) | irq_evt;

  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      wan_sel    <= 1'b0;
      wan_active <= 1'b0;
      a1a2       <= `WSO_RST_A1A2;
      z0e1       <= `WSO_RST_Z0E1;
      f1d1       <= `WSO_RST_F1D1;
      d2d3       <= `WSO_RST_D2D3;
      tx_len     <= `WSO_RST_LEN;
      rx_len     <= `WSO_RST_LEN;
      irq_stat   <= 3'h0;
      irq_mask   <= 3'h0;
      irq_o      <= 1'b0;
    end else begin
      wan_active <= wan_sel;
      irq_stat   <= next_irq_stat;                               // set wins over clear
      irq_o      <= |(next_irq_stat & irq_mask);
      if (wr_ctl) begin
        case (addr_i)
          `WSO_ADDR_CTRL:     wan_sel  <= wr_data_i[`WSO_CTRL_WAN_BIT];
          `WSO_ADDR_A1A2:     a1a2     <= wr_data_i;
          `WSO_ADDR_Z0E1:     z0e1     <= wr_data_i;
          `WSO_ADDR_F1D1:     f1d1     <= wr_data_i;
          `WSO_ADDR_D2D3:     d2d3     <= wr_data_i;
          `WSO_ADDR_TXLEN:    tx_len   <= wr_data_i[1:0];
          `WSO_ADDR_RXLEN:    rx_len   <= wr_data_i[1:0];
          `WSO_ADDR_IRQ_MASK: irq_mask <= wr_data_i[2:0];
          default: ;
        endcase
      end
    end
  end

  // Transmit trace store, two bytes per word
  wire       tmsg_hit = addr_i[15:5] == `WSO_ADDR_TXMSG >> 5;
  wire       rmsg_hit = addr_i[15:5] == `WSO_ADDR_RXMSG >> 5;
  wire [5:0] msg_lo   = {addr_i[4:0], 1'b0};
  wire [5:0] msg_hi   = {addr_i[4:0], 1'b1};

  always @(posedge clock_i) begin
    if (wr_ctl && tmsg_hit) begin
      tx_msg[msg_lo] <= wr_data_i[7:0];
      tx_msg[msg_hi] <= wr_data_i[15:8];
    end
  end

  // ==========================================================
  // Register reads, data one cycle after the strobe
  reg [15:0] rd_val;

  always @* begin
    rd_val = 16'h0000;
    case (addr_i)
      `WSO_ADDR_CTRL:     rd_val = {15'h0000, wan_sel};
      `WSO_ADDR_STAT:     rd_val = {12'h000, wan_active, 2'h0, rstate};
      `WSO_ADDR_A1A2:     rd_val = a1a2;
      `WSO_ADDR_Z0E1:     rd_val = z0e1;
      `WSO_ADDR_F1D1:     rd_val = f1d1;
      `WSO_ADDR_D2D3:     rd_val = d2d3;
      `WSO_ADDR_TXLEN:    rd_val = {14'h0000, tx_len};
      `WSO_ADDR_RXLEN:    rd_val = {14'h0000, rx_len};
      `WSO_ADDR_TALLY_HI: rd_val = tally_hi;
      `WSO_ADDR_TALLY_LO: rd_val = tally_lo;
      `WSO_ADDR_IRQ_STAT: rd_val = {13'h0000, irq_stat};
      `WSO_ADDR_IRQ_MASK: rd_val = {13'h0000, irq_mask};
      default: begin
        if (tmsg_hit)
          rd_val = {tx_msg[msg_hi], tx_msg[msg_lo]};
        else if (rmsg_hit)
          rd_val = {rx_msg[msg_hi], rx_msg[msg_lo]};
      end
    endcase
  end

  always @(posedge clock_i) begin
    if (!rst_n_i)
      rd_data_o <= 16'h0000;
    else if (rd_stb_i)
      rd_data_o <= rd_val;
  end

endmodule // wso_framer

//--- testbench/wso_framer_assertions.sv
`timescale 1ns/1ns
// ====
// Port checker for the framer
module wso_framer_assertions (
  input wire        clock_i,
  input wire        rst_n_i,
  input wire [15:0] addr_i,
  input wire [15:0] wr_data_i,
  input wire        wr_stb_i,
  input wire        rd_stb_i,
  input wire [15:0] rd_data_o,
  input wire        irq_o,
  input wire        pcs_tx_valid_i,
  input wire        pcs_tx_ready_o,
  input wire [7:0]  pma_tx_data_o,
  input wire        pma_tx_valid_o,
  input wire [3:0]  tx_osp_code_o,
  input wire        tx_osp_en_i,
  input wire        rx_osp_valid_o,
  input wire [3:0]  rx_osp_code_o
);
  reg [2:0] wan_h;
  reg       mz;
  reg       mz_d;
  // Mode history and all-masked state, taken from bus writes
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      wan_h <= 3'h0;
      mz    <= 1'b0;
      mz_d  <= 1'b0;
    end else begin
      wan_h <= {wan_h[1:0], (wr_stb_i && addr_i == 16'h0007) ? wr_data_i[0] : wan_h[0]};
      if (wr_stb_i && addr_i == 16'hE609)
        mz <= (wr_data_i[2:0] == 3'h0);
      mz_d  <= mz;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_lan_ready: assert property (wan_h == 3'h0 |-> pcs_tx_ready_o)
    else $error("ready low in LAN mode");
  a_lan_valid: assert property (wan_h == 3'h0 && $past(rst_n_i)
    |-> pma_tx_valid_o == $past(pcs_tx_valid_i)) else $error("LAN valid not copied");
  a_wan_valid: assert property (&wan_h |-> pma_tx_valid_o)
    else $error("WAN stream not continuous");
  a_status_wan: assert property (rd_stb_i && addr_i == 16'hA101
    && (&wan_h || wan_h == 3'h0) |=> rd_data_o[3] == $past(wan_h[0]))
    else $error("WAN status bit wrong");
  a_read_hold: assert property (!rd_stb_i |=> $stable(rd_data_o))
    else $error("read data moved without read");
  a_irq_masked: assert property (mz && mz_d |-> !irq_o)
    else $error("interrupt while fully masked");
  a_tx_framing: assert property ((tx_osp_code_o == 4'h1 || tx_osp_code_o == 4'h2)
    && !tx_osp_en_i ##1 !tx_osp_en_i
    |-> pma_tx_data_o == ($past(tx_osp_code_o) == 4'h1 ? 8'hF6 : 8'h28))
    else $error("framing octet wrong");
  a_rx_code: assert property (rx_osp_valid_o |-> rx_osp_code_o != 4'h0
    && rx_osp_code_o <= 4'hA) else $error("bad receive octet code");
endmodule // wso_framer_assertions

//--- testbench/wso_far_model.sv
`timescale 1ns/1ns
// ====
// Far side: counting PCS source and PMA loopback line
module wso_far_model (
  input  wire       clock_i,
  input  wire       rst_n_i,
  input  wire       pcs_tx_ready_i,
  input  wire [7:0] pma_tx_data_i,
  input  wire       pma_tx_valid_i,
  output reg  [7:0] pcs_tx_data_o,
  output reg        pcs_tx_valid_o,
  output reg  [7:0] pma_rx_data_o,
  output reg        pma_rx_valid_o
);
  // Source advances per accepted byte; idle line inverts its previous value every cycle
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      pcs_tx_data_o  <= 8'h00;
      pcs_tx_valid_o <= 1'b0;
      pma_rx_data_o  <= 8'h00;
      pma_rx_valid_o <= 1'b0;
    end else begin
      pcs_tx_valid_o <= 1'b1;
      if (pcs_tx_ready_i && pcs_tx_valid_o)
        pcs_tx_data_o <= pcs_tx_data_o + 8'h01;
      pma_rx_valid_o <= pma_tx_valid_i;
      pma_rx_data_o  <= pma_tx_valid_i ? pma_tx_data_i : ~pma_rx_data_o;
    end
  end
endmodule // wso_far_model

//--- testbench/tb_top.sv
`timescale 1ns/1ns
// ====
// Framer bench, far side looped back
module tb_top;
  localparam NS = 2;
  reg         clock_i = 1'b0;
  reg         rst_n_i = 1'b0;
  reg  [15:0] addr_i = 16'h0000;
  reg  [15:0] wr_data_i = 16'h0000;
  reg         wr_stb_i = 1'b0;
  reg         rd_stb_i = 1'b0;
  reg         tx_osp_en_i = 1'b0;
  reg  [7:0]  tx_osp_byte_i = 8'h00;
  reg         inj = 1'b0;
  reg  [15:0] tos = 16'h0000;
  wire [15:0] rd_data_o;
  wire [7:0]  pcs_tx_data_i, pma_tx_data_o, pma_rx_data_i, pcs_rx_data_o, rx_osp_byte_o;
  wire        irq_o, pcs_tx_valid_i, pcs_tx_ready_o, pma_tx_valid_o, pma_rx_valid_i;
  wire        pcs_rx_valid_o, rx_osp_valid_o;
  wire [3:0]  tx_osp_code_o, rx_osp_code_o;
  integer     err_total = 0;
  integer     checks = 0;
  integer     k;
  integer     i;
  reg  [15:0] v;
  reg  [15:0] n;
  reg  [7:0]  p;
  always #5 clock_i = ~clock_i;
  wso_framer #(.N(NS), .LATCH_FRAMES(2)) i_dut (.clock_i, .rst_n_i, .addr_i, .wr_data_i,
    .wr_stb_i, .rd_stb_i, .rd_data_o, .irq_o, .pcs_tx_data_i, .pcs_tx_valid_i,
    .pcs_tx_ready_o, .pma_tx_data_o, .pma_tx_valid_o, .pma_rx_data_i, .pma_rx_valid_i,
    .pcs_rx_data_o, .pcs_rx_valid_o, .tx_osp_code_o, .tx_osp_en_i, .tx_osp_byte_i,
    .rx_osp_code_o, .rx_osp_byte_o, .rx_osp_valid_o);
  wso_far_model i_far (.clock_i, .rst_n_i, .pcs_tx_ready_i(pcs_tx_ready_o),
    .pma_tx_data_i(pma_tx_data_o), .pma_tx_valid_i(pma_tx_valid_o),
    .pcs_tx_data_o(pcs_tx_data_i), .pcs_tx_valid_o(pcs_tx_valid_i),
    .pma_rx_data_o(pma_rx_data_i), .pma_rx_valid_o(pma_rx_valid_i));
  // Overhead port masks the parity octet while injection is on; the enable must
  // stand while the parity slot is current, so count down from the growth octet
  always @(posedge clock_i) begin
    if (tx_osp_code_o === 4'h4)
      tos <= 87 * NS;
    else if (tos != 16'h0000)
      tos <= tos - 16'h0001;
    tx_osp_en_i   <= inj && tos == 16'h0001;
    tx_osp_byte_i <= 8'h5A;
  end
  // ====
  // Shared tasks
  task conclude;
    begin
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [15:0] a, input [15:0] d);
    begin
      @(posedge clock_i);
      addr_i    <= a;
      wr_data_i <= d;
      wr_stb_i  <= 1'b1;
      @(posedge clock_i);
      wr_stb_i  <= 1'b0;
    end
  endtask
  task rd(input [15:0] a, output [15:0] q);
    begin
      @(posedge clock_i);
      addr_i   <= a;
      rd_stb_i <= 1'b1;
      @(posedge clock_i);
      rd_stb_i <= 1'b0;
      #1;
      q = rd_data_o;
    end
  endtask
  task wt(input rx, input [3:0] c);
    integer j;
    begin
      j = 0;
      do begin
        @(posedge clock_i);
        #1;
        j = j + 1;
      end while (j < 4000 && (rx ? !(rx_osp_valid_o === 1'b1 && rx_osp_code_o === c)
                 : tx_osp_code_o !== c));
      if (j >= 4000) begin
        err_total = err_total + 1;
        conclude;
      end
    end
  endtask
  task ob(input [3:0] c, input [7:0] b);
    begin
      wt(1'b1, c);
      chk({8'h00, rx_osp_byte_o}, {8'h00, b});
    end
  endtask
  task run(input [3:0] c, input [7:0] b);
    begin
      n = 0;
      while (tx_osp_code_o === c && n < 16'h0100) begin
        n = n + 1;
        @(posedge clock_i);
        #1;
      end
      chk(n, NS);
      chk({8'h00, pma_tx_data_o}, {8'h00, b});
    end
  endtask
  // ====
  // Scenarios
  task t_regs;
    begin
      rd(16'hE600, v);
      chk(v, 16'hF628);
      rd(16'hE601, v);
      chk(v, 16'hCC00);
      rd(16'hE602, v);
      chk(v, 16'h0000);
      rd(16'hE603, v);
      chk(v, 16'h0000);
      rd(16'h0100, v);
      chk(v, 16'h0000);
      wr(16'hE604, 16'h0002);
      rd(16'hE604, v);
      chk(v, 16'h0002);
      wr(16'hE604, 16'h0000);
      rd(16'hA101, v);
      chk(v & 16'h0008, 16'h0000);
    end
  endtask
  task t_mode(input [15:0] m);
    begin
      wr(16'h0007, m);
      repeat (3) @(posedge clock_i);
      rd(16'hA101, v);
      chk(v & 16'h0008, {m[12:0], 3'h0});
      chk({15'h0, m[0] ? pma_tx_valid_o : pcs_tx_ready_o}, 16'h0001);
    end
  endtask
  task t_frame;
    begin
      wt(1'b0, 4'h2);
      wt(1'b0, 4'h1);
      run(4'h1, 8'hF6);
      run(4'h2, 8'h28);
      @(posedge clock_i);
      #1;
      chk({8'h00, pma_tx_data_o}, 16'h00A5);
      @(posedge clock_i);
      #1;
      chk({8'h00, pma_tx_data_o}, 16'h00CC);
    end
  endtask
  task t_rx;
    begin
      wr(16'hE601, 16'hC3E7);
      wr(16'hE602, 16'h5A3C);
      wr(16'hE603, 16'h1234);
      repeat (2) begin
        ob(4'h3, 8'hA5);
        ob(4'h4, 8'hC3);
        ob(4'h6, 8'hE7);
        ob(4'h7, 8'h5A);
        ob(4'h8, 8'h3C);
        ob(4'h9, 8'h12);
        ob(4'hA, 8'h34);
      end
      rd(16'hA101, v);
      chk(v & 16'h0001, 16'h0001);
      rd(16'hE680, v);
      chk(v & 16'h00FF, 16'h00A5);
    end
  endtask
  task t_pay;
    begin
      k = 0;
      i = 0;
      while (k < 40 && i < 3000) begin
        @(posedge clock_i);
        #1;
        i = i + 1;
        if (pcs_rx_valid_o === 1'b1) begin
          if (k == 0)
            p = pcs_rx_data_o;
          else
            chk({8'h00, pcs_rx_data_o}, {8'h00, p + k[7:0]});
          k = k + 1;
        end
      end
      chk(k[15:0], 16'd40);
    end
  endtask
  task t_b1;
    begin
      wr(16'hE609, 16'h0001);
      wr(16'hE608, 16'h0007);
      inj = 1'b1;
      wt(1'b1, 4'h5);
      ob(4'h5, 8'h5A);
      ob(4'h5, 8'h5A);
      chk({15'h0, irq_o}, 16'h0001);
      wr(16'hE609, 16'h0000);
      rd(16'hE608, v);
      chk(v & 16'h0001, 16'h0001);
      chk({15'h0, irq_o}, 16'h0000);
      repeat (3) wt(1'b0, 4'h3);
      rd(16'hE606, v);
      chk(v, 16'h0000);
      rd(16'hE607, v);
      chk(v, 16'h0008);
      inj = 1'b0;
      wt(1'b1, 4'h5);
      ob(4'h5, 8'h00);
      wr(16'hE609, 16'h0001);
      wr(16'hE608, 16'h0001);
      rd(16'hE608, v);
      chk(v & 16'h0001, 16'h0000);
      chk({15'h0, irq_o}, 16'h0000);
    end
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_regs;
    wr(16'hE640, 16'h00A5);
    t_mode(16'h0001);
    t_frame;
    t_rx;
    t_pay;
    t_b1;
    t_mode(16'h0000);
    conclude;
  end
endmodule // tb_top
bind wso_framer wso_framer_assertions u_chk (.clock_i, .rst_n_i, .addr_i, .wr_data_i,
  .wr_stb_i, .rd_stb_i, .rd_data_o, .irq_o, .pcs_tx_valid_i, .pcs_tx_ready_o,
  .pma_tx_data_o, .pma_tx_valid_o, .tx_osp_code_o, .tx_osp_en_i, .rx_osp_valid_o,
  .rx_osp_code_o);
